// ==== tb/gsp_ext_cpu.sv ====
// External processor model on the far side of the slave port
`timescale 1ns/10ps
`default_nettype none
module gsp_ext_cpu (
    // Clock
    input wire logic core_clk,
    // Slave bus from the block
    input wire logic [7:0] slave_data_out,
    input wire logic slave_data_oe,
    // Strobes [2]=select [1]=write [0]=read, all active low, and data
    output logic [2:0] strobe_n,
    output logic [7:0] data
);
    initial begin
        strobe_n = 3'h7;
        data = 8'h00;
    end
    // ********
    // Bus cycles
    // ********
    task automatic write_word(input logic [7:0] d);
        @(posedge core_clk);
        strobe_n <= 3'h1;
        data <= d;
        repeat (2) @(posedge core_clk);
        strobe_n <= 3'h7;
        @(posedge core_clk);
        // Released bus must not keep showing the old word
        data <= ~d;
    endtask
    task automatic read_word(output logic [7:0] d, output logic oe);
        @(posedge core_clk);
        strobe_n <= 3'h2;
        repeat (2) @(posedge core_clk);
        #1;
        d = slave_data_out;
        oe = slave_data_oe;
        @(posedge core_clk);
        strobe_n <= 3'h7;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ==== tb/gsp_port_io_test.sv ====
// Self-checking bench for the eight-pin port and the slave port
`timescale 1ns/10ps
`default_nettype none
module gsp_port_io_test
    import gsp_pkg::*;
;
    typedef struct packed {
        logic [7:0] latch, dir, sel, pout, poe, fen, fout, out, oe, rb;
    } gsp_row_type;
    logic core_clk, reset, reg_write, reg_read, ccp, sck, sdi, sd_oe, mode, ext_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sel, pout, poe, fen, fout;
    logic [7:0] pins_in, p_out, p_oe, sd_in, sd_out, ext_d;
    logic [2:0] t_in, t_out, t_oe;
    int failures, compares;
    gsp_row_type rows [5] = '{
        '{8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5, 8'hff, 8'h00},
        '{8'ha5, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5, 8'hf0, 8'h0f},
        '{8'h0f, 8'hff, 8'hf0, 8'h3c, 8'h50, 8'h00, 8'h00, 8'h3f, 8'h50, 8'hff},
        '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h24, 8'h00, 8'he4, 8'h1b},
        '{8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff}};
    logic [7:0] taps [2] = '{8'h14, 8'h28};
    logic [7:0] taps_exp [2] = '{8'h05, 8'h02};

    gsp_port_io i_gsp_port_io (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .periph_sel(sel), .periph_out(pout), .periph_oe(poe),
        .periph_force_en(fen), .periph_force_out(fout), .capture_compare_pwm_in(ccp),
        .serial_clock_in(sck), .serial_data_in(sdi), .eight_pin_port_in(pins_in),
        .eight_pin_port_out(p_out), .eight_pin_port_oe(p_oe), .three_pin_port_in(t_in),
        .three_pin_port_out(t_out), .three_pin_port_oe(t_oe), .slave_data_in(sd_in),
        .slave_data_out(sd_out), .slave_data_oe(sd_oe), .slave_port_mode(mode));
    gsp_ext_cpu i_gsp_ext_cpu (.core_clk(core_clk), .slave_data_out(sd_out),
        .slave_data_oe(sd_oe), .strobe_n(t_in), .data(sd_in));

    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        {reg_write, reg_read, reg_addr, reg_wdata} = '0;
        {sel, pout, poe, fen, fout, pins_in} = '0;
        failures = 0;
        compares = 0;
    end
    always #10 core_clk = ~core_clk;
    // ********
    // Shared tasks
    // ********
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        check8(what, exp, reg_rdata);
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_EIGHT_PIN_PORT_DIRECTION, 8'hff, "dir_reset");
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h07, "ctrl_reset");
        check8("oe_reset", 8'h00, p_oe);
    endtask
    task automatic summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        do_reset();
        // Direction is always written whole, never read-modify-write, under override
        foreach (rows[i]) begin
            wr(ADDR_EIGHT_PIN_PORT, rows[i].latch);
            wr(ADDR_EIGHT_PIN_PORT_DIRECTION, rows[i].dir);
            sel <= rows[i].sel;
            pout <= rows[i].pout;
            poe <= rows[i].poe;
            fen <= rows[i].fen;
            fout <= rows[i].fout;
            repeat (3) @(posedge core_clk);
            #1;
            check8("pin_out", rows[i].out, p_out);
            check8("pin_oe", rows[i].oe, p_oe);
            rd(ADDR_EIGHT_PIN_PORT_DIRECTION, rows[i].rb, "dir_read");
        end
        foreach (taps[i]) begin
            @(posedge core_clk);
            {sel, pout, poe, fen, fout} <= '0;
            pins_in <= taps[i];
            @(posedge core_clk);
            #1;
            check8("pin_taps", taps_exp[i], {5'h00, ccp, sck, sdi});
        end
        rd(ADDR_EIGHT_PIN_PORT, 8'h28, "port_pins");
        wr(ADDR_THREE_PIN_PORT, 8'h05);
        wr(ADDR_THREE_PIN_PORT_CONTROL, 8'h02);
        repeat (2) @(posedge core_clk);
        #1;
        check8("three_oe", 8'h05, {5'h00, t_oe});
        check8("three_out", 8'h05, {5'h00, t_out});
        rd(ADDR_THREE_PIN_PORT, 8'h07, "three_pins");
        // Strobes from outside must be ignored in port mode
        i_gsp_ext_cpu.write_word(8'h3c);
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h02, "ctrl_io_mode");
        wr(ADDR_THREE_PIN_PORT_CONTROL, 8'h17);
        repeat (2) @(posedge core_clk);
        #1;
        check8("mode", 8'h01, {7'h00, mode});
        check8("three_oe_slave", 8'h00, {5'h00, t_oe});
        i_gsp_ext_cpu.write_word(8'ha1);
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h97, "ibf_set");
        i_gsp_ext_cpu.write_word(8'hb2);
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'hb7, "input_overflow_set");
        rd(ADDR_SLAVE_DATA, 8'hb2, "slave_in");
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h37, "ibf_clear");
        wr(ADDR_THREE_PIN_PORT_CONTROL, 8'hf7);
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h37, "status_ro");
        wr(ADDR_THREE_PIN_PORT_CONTROL, 8'h17);
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h17, "input_overflow_clear");
        wr(ADDR_SLAVE_DATA, 8'hc3);
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h57, "obf_set");
        i_gsp_ext_cpu.read_word(ext_d, ext_oe);
        check8("ext_data", 8'hc3, ext_d);
        check8("ext_oe", 8'h01, {7'h00, ext_oe});
        rd(ADDR_THREE_PIN_PORT_CONTROL, 8'h17, "obf_clear");
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00, "unmapped");
        wr(ADDR_EIGHT_PIN_PORT_DIRECTION, 8'h00);
        do_reset();
        summarize();
    end
    // Whole run takes well under two hundred cycles; this is far beyond it
    initial begin
        repeat (4000) @(posedge core_clk);
        failures++;
        summarize();
    end
endmodule
`default_nettype wire

// ==== verilog/gsp_pin_cell.sv ====
// One pin of the eight-pin port: output mux, direction and override
`timescale 1ns/10ps
`default_nettype none
module gsp_pin_cell (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Port state
    input wire logic latch_bit,
    input wire logic dir_bit,
    // Peripheral side
    input wire logic periph_sel,
    input wire logic periph_out,
    input wire logic periph_oe,
    input wire logic force_en,
    input wire logic force_out,
    // Pin side
    output logic pin_out,
    output logic pin_oe,
    output logic effective_dir
);
    logic next_pin_out;
    logic next_pin_oe;

    always_comb begin
        // Peripheral enable counts only when the pin is handed to it
        if (periph_sel) begin
            next_pin_out = periph_out;
            next_pin_oe = periph_oe;
        end else if (force_en) begin
            next_pin_out = latch_bit;
            next_pin_oe = force_out;
        end else begin
            next_pin_out = latch_bit;
            next_pin_oe = ~dir_bit;
        end
    end

    // Software sees the forced direction while force_en is set, otherwise the stored bit, even when the select hands the pin to periph_oe
    assign effective_dir = force_en ? ~force_out : dir_bit;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/gsp_pkg.sv ====
// Shared constants for the general-purpose port and slave-port block
package gsp_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_EIGHT_PIN_PORT = 8'h07;
    localparam logic [7:0] ADDR_SLAVE_DATA = 8'h08;
    localparam logic [7:0] ADDR_THREE_PIN_PORT = 8'h09;
    localparam logic [7:0] ADDR_EIGHT_PIN_PORT_DIRECTION = 8'h87;
    localparam logic [7:0] ADDR_THREE_PIN_PORT_CONTROL = 8'h89;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_INPUT_BUFFER_FULL = 7;
    localparam int BIT_OUTPUT_BUFFER_FULL = 6;
    localparam int BIT_INPUT_OVERFLOW = 5;
    localparam int BIT_SLAVE_PORT_MODE_SELECT = 4;
    localparam int THREE_PIN_WIDTH = 3;
    localparam int PIN_CHIP_SELECT = 2;
    localparam int PIN_WRITE_STROBE = 1;
    localparam int PIN_READ_STROBE = 0;
    localparam int PIN_CAPTURE_COMPARE_PWM = 2;
    localparam int PIN_SERIAL_CLOCK = 3;
    localparam int PIN_SERIAL_DATA_IN = 4;
    localparam int PIN_SERIAL_DATA_OUT = 5;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] EIGHT_PIN_DIRECTION_RESET = 8'hff;
    localparam logic [2:0] THREE_PIN_DIRECTION_RESET = 3'h7;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;
    // ****************************************
    // Slave bus phases
    // ****************************************
    typedef enum logic [1:0] {
        GSP_IDLE = 2'b00,
        GSP_WRITING = 2'b01,
        GSP_READING = 2'b10
    } gsp_bus_state_type;
endpackage

// ==== verilog/gsp_port_io.sv ====
// Eight-pin port and three-pin port with parallel slave port mode
// Functional notes
// - Every pin of the eight-pin port has its own direction bit, 1 for input.
// - An enabled peripheral may force a pin to output or input over the direction bit.
// - A per-pin select feeds the driver from the port latch or the peripheral output.
// - The peripheral output enable acts only while that pin's select is active.
// - Pins 2, 3, 4 and 5 carry capture/compare/PWM, serial clock, serial data in and out.
// - The eight-pin direction register resets to all ones.
// - The three-pin port has chip select, write and read pins, each with a direction bit.
// - Slave mode (control bit 4) turns the three pins into slave control inputs.
// - Bit 7 shows a word from the external processor waits for the CPU.
// - Bit 6 shows a CPU word still unread by the external processor.
// - Bit 5 flags a write that lands on an unread word; only software clears it.
// - The mode bit resets to 0 and the three direction bits reset to 1.
`timescale 1ns/10ps
`default_nettype none
module gsp_port_io
    import gsp_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Peripherals sharing the eight-pin port
    input wire logic [PORT_WIDTH-1:0] periph_sel,
    input wire logic [PORT_WIDTH-1:0] periph_out,
    input wire logic [PORT_WIDTH-1:0] periph_oe,
    input wire logic [PORT_WIDTH-1:0] periph_force_en,
    input wire logic [PORT_WIDTH-1:0] periph_force_out,
    output logic capture_compare_pwm_in,
    output logic serial_clock_in,
    output logic serial_data_in,
    // Eight-pin port pins
    input wire logic [PORT_WIDTH-1:0] eight_pin_port_in,
    output logic [PORT_WIDTH-1:0] eight_pin_port_out,
    output logic [PORT_WIDTH-1:0] eight_pin_port_oe,
    // Three-pin port pins
    input wire logic [2:0] three_pin_port_in,
    output logic [2:0] three_pin_port_out,
    output logic [2:0] three_pin_port_oe,
    // Slave data bus
    input wire logic [7:0] slave_data_in,
    output logic [7:0] slave_data_out,
    output logic slave_data_oe,
    output logic slave_port_mode
);
    // ****************************************
    // Elaboration check
    // ****************************************
    if (PORT_WIDTH != 8) begin : g_width_check
        $error("PORT_WIDTH must be 8 to fit the byte-wide registers");
    end

    // ****************************************
    // Register state
    // ****************************************
    logic [PORT_WIDTH-1:0] eight_pin_port, next_eight_pin_port;
    logic [PORT_WIDTH-1:0] eight_pin_port_direction, next_eight_pin_port_direction;
    logic [PORT_WIDTH-1:0] effective_direction;
    logic [2:0] three_pin_port, next_three_pin_port;
    logic [2:0] three_pin_direction, next_three_pin_direction;
    logic next_slave_port_mode;
    logic [2:0] next_three_pin_oe;
    logic [7:0] next_reg_rdata;
    logic slave_write, slave_read, overflow_clear;
    logic [7:0] input_latch;
    logic input_buffer_full, output_buffer_full, input_overflow;

    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction

    assign slave_write = hit(reg_write, reg_addr, ADDR_SLAVE_DATA);
    assign slave_read = hit(reg_read, reg_addr, ADDR_SLAVE_DATA);
    // Writing 0 to the overflow bit is the only way to clear it
    assign overflow_clear = hit(reg_write, reg_addr, ADDR_THREE_PIN_PORT_CONTROL)
                            && !reg_wdata[BIT_INPUT_OVERFLOW];

    // ****************************************
    // Register writes
    // ****************************************
    always_comb begin
        next_eight_pin_port = eight_pin_port;
        next_eight_pin_port_direction = eight_pin_port_direction;
        next_three_pin_port = three_pin_port;
        next_three_pin_direction = three_pin_direction;
        next_slave_port_mode = slave_port_mode;
        if (hit(reg_write, reg_addr, ADDR_EIGHT_PIN_PORT)) begin
            next_eight_pin_port = reg_wdata;
        end
        if (hit(reg_write, reg_addr, ADDR_EIGHT_PIN_PORT_DIRECTION)) begin
            next_eight_pin_port_direction = reg_wdata;
        end
        if (hit(reg_write, reg_addr, ADDR_THREE_PIN_PORT)) begin
            next_three_pin_port = reg_wdata[2:0];
        end
        if (hit(reg_write, reg_addr, ADDR_THREE_PIN_PORT_CONTROL)) begin
            // Status bits 7 and 6 ignore writes
            next_three_pin_direction = reg_wdata[2:0];
            next_slave_port_mode = reg_wdata[BIT_SLAVE_PORT_MODE_SELECT];
        end
        // Slave mode drops all three drivers whatever the direction bits say
        next_three_pin_oe = next_slave_port_mode ? 3'h0 : ~next_three_pin_direction;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            eight_pin_port <= LATCH_RESET;
            eight_pin_port_direction <= EIGHT_PIN_DIRECTION_RESET;
            three_pin_port <= LATCH_RESET[2:0];
            three_pin_direction <= THREE_PIN_DIRECTION_RESET;
            slave_port_mode <= 1'b0;
            three_pin_port_out <= LATCH_RESET[2:0];
            three_pin_port_oe <= 3'h0;
        end else begin
            eight_pin_port <= next_eight_pin_port;
            eight_pin_port_direction <= next_eight_pin_port_direction;
            three_pin_port <= next_three_pin_port;
            three_pin_direction <= next_three_pin_direction;
            slave_port_mode <= next_slave_port_mode;
            three_pin_port_out <= next_three_pin_port;
            three_pin_port_oe <= next_three_pin_oe;
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_comb begin
        next_reg_rdata = READ_NONE;
        if (reg_read) begin
            case (reg_addr)
                ADDR_EIGHT_PIN_PORT: next_reg_rdata = eight_pin_port_in;
                // Overrides show through, so read-modify-write is unsafe
                ADDR_EIGHT_PIN_PORT_DIRECTION: next_reg_rdata = effective_direction;
                ADDR_THREE_PIN_PORT: next_reg_rdata = {5'h00, three_pin_port_in};
                ADDR_SLAVE_DATA: next_reg_rdata = input_latch;
                ADDR_THREE_PIN_PORT_CONTROL: next_reg_rdata = {input_buffer_full,
                    output_buffer_full, input_overflow, slave_port_mode, 1'b0,
                    three_pin_direction};
                default: next_reg_rdata = READ_NONE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= READ_NONE;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ****************************************
    // Eight-pin port cells
    // ****************************************
    for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_cell
        gsp_pin_cell u_cell (
            .core_clk(core_clk),
            .reset(reset),
            .latch_bit(eight_pin_port[i]),
            .dir_bit(eight_pin_port_direction[i]),
            .periph_sel(periph_sel[i]),
            .periph_out(periph_out[i]),
            .periph_oe(periph_oe[i]),
            .force_en(periph_force_en[i]),
            .force_out(periph_force_out[i]),
            .pin_out(eight_pin_port_out[i]),
            .pin_oe(eight_pin_port_oe[i]),
            .effective_dir(effective_direction[i])
        );
    end

    // Shared-function inputs go straight to their peripherals
    assign capture_compare_pwm_in = eight_pin_port_in[PIN_CAPTURE_COMPARE_PWM];
    assign serial_clock_in = eight_pin_port_in[PIN_SERIAL_CLOCK];
    assign serial_data_in = eight_pin_port_in[PIN_SERIAL_DATA_IN];

    // ****************************************
    // Parallel slave port
    // ****************************************
    // Strobes are taken from the pins even if software left a driver on;
    // the slave mode forces the drivers off anyway
    gsp_slave_latch u_slave (
        .core_clk(core_clk),
        .reset(reset),
        .mode(slave_port_mode),
        .chip_select_n(three_pin_port_in[PIN_CHIP_SELECT]),
        .write_strobe_n(three_pin_port_in[PIN_WRITE_STROBE]),
        .read_strobe_n(three_pin_port_in[PIN_READ_STROBE]),
        .bus_in(slave_data_in),
        .bus_out(slave_data_out),
        .bus_oe(slave_data_oe),
        .cpu_write(slave_write),
        .cpu_wdata(reg_wdata),
        .cpu_read(slave_read),
        .overflow_clear(overflow_clear),
        .input_latch(input_latch),
        .input_buffer_full(input_buffer_full),
        .output_buffer_full(output_buffer_full),
        .input_overflow(input_overflow)
    );

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_direction_reset:
    assert property ($fell(reset) |-> eight_pin_port_direction == 8'hff)
        else $error("direction register not all ones after reset");

    a_control_reset:
    assert property ($fell(reset) |-> !slave_port_mode && three_pin_direction == 3'h7)
        else $error("three-pin control reset value wrong");

    a_direction_drives:
    assert property (hit(reg_write, reg_addr, ADDR_EIGHT_PIN_PORT_DIRECTION)
        && periph_sel == 8'h00 && periph_force_en == 8'h00
        ##1 periph_sel == 8'h00 && periph_force_en == 8'h00
        |=> eight_pin_port_oe == ~$past(reg_wdata, 2))
        else $error("direction write did not reach the drivers");

    a_force_output:
    assert property (!periph_sel[2] && periph_force_en[2]
        |=> eight_pin_port_oe[2] == $past(periph_force_out[2]))
        else $error("peripheral direction override ignored");

    a_select_data:
    assert property (periph_sel[5] |=> eight_pin_port_out[5] == $past(periph_out[5]))
        else $error("peripheral output not routed to pin");

    a_select_enable:
    assert property (periph_sel[3] |=> eight_pin_port_oe[3] == $past(periph_oe[3]))
        else $error("peripheral enable not applied while selected");

    a_latch_data:
    assert property (!periph_sel[0] |=> eight_pin_port_out[0] == $past(eight_pin_port[0]))
        else $error("port latch not driven on deselected pin");

    a_slave_inputs:
    assert property (slave_port_mode |-> three_pin_port_oe == 3'h0)
        else $error("three-pin driver on in slave mode");

    a_ibf_clear_cause:
    assert property ($fell(input_buffer_full) |-> $past(slave_read))
        else $error("input full cleared without a CPU read");

    a_obf_after_write:
    assert property (slave_write |=> output_buffer_full)
        else $error("output full not set by CPU write");

    a_overflow_sticky:
    assert property (input_overflow && !overflow_clear |=> input_overflow)
        else $error("overflow flag lost without software clear");

    a_overflow_cause:
    assert property ($rose(input_overflow) |-> $past(input_buffer_full))
        else $error("overflow set while input buffer was empty");

    a_read_latency:
    assert property (hit(reg_read, reg_addr, ADDR_THREE_PIN_PORT_CONTROL)
        |=> reg_rdata[7] == $past(input_buffer_full))
        else $error("status read does not show input full");

    // Read data follow one cycle after the strobe
    a_pin_readback:
    assert property (hit(reg_read, reg_addr, ADDR_EIGHT_PIN_PORT)
        |=> reg_rdata == $past(eight_pin_port_in))
        else $error("pin read wrong");

    a_dir_readback:
    assert property (hit(reg_read, reg_addr, ADDR_EIGHT_PIN_PORT_DIRECTION)
        |=> reg_rdata == $past(~periph_force_out & periph_force_en
        | eight_pin_port_direction & ~periph_force_en))
        else $error("direction read wrong");

    a_ctrl_readback:
    assert property (hit(reg_read, reg_addr, ADDR_THREE_PIN_PORT_CONTROL)
        |=> reg_rdata[4:0] == $past({slave_port_mode, 1'b0, three_pin_direction}))
        else $error("control read wrong");

    a_latch_readback:
    assert property (hit(reg_read, reg_addr, ADDR_SLAVE_DATA)
        |=> reg_rdata == $past(input_latch))
        else $error("slave data read wrong");

    a_oe_reset:
    assert property ($fell(reset) |-> eight_pin_port_oe == 8'h00)
        else $error("pins driven after reset");

    // Mode, direction and enable load on one edge
    a_three_pin_drive:
    assert property (!slave_port_mode |-> three_pin_port_oe == ~three_pin_direction)
        else $error("three-pin enable wrong");

    a_mode_quiet:
    assert property (!slave_port_mode |=> !slave_data_oe)
        else $error("slave bus on in port mode");

    a_ibf_set_cause:
    assert property ($rose(input_buffer_full) |-> $past(slave_port_mode))
        else $error("input full without mode");

    a_ibf_stays:
    assert property (input_buffer_full && !slave_read |=> input_buffer_full)
        else $error("input full lost");

    a_obf_clear_cause:
    assert property ($fell(output_buffer_full) |-> $past(slave_data_oe))
        else $error("output full cleared early");

    a_obf_stays:
    assert property (output_buffer_full && !slave_data_oe |=> output_buffer_full)
        else $error("output full lost");

    a_overflow_mode:
    assert property ($rose(input_overflow) |-> $past(slave_port_mode))
        else $error("overflow without mode");

    c_overflow: cover property ($rose(input_overflow));
    c_ext_read_done: cover property ($fell(output_buffer_full));
    c_ext_write_then_cpu_read: cover property ($rose(input_buffer_full) ##[1:20]
        $fell(input_buffer_full));
    c_force_input: cover property (periph_force_en[4] && !periph_force_out[4]);
    c_slave_read: cover property ($rose(slave_data_oe));
endmodule
`default_nettype wire

// ==== verilog/gsp_slave_latch.sv ====
// Parallel slave port latches and buffer status
`timescale 1ns/10ps
`default_nettype none
module gsp_slave_latch
    import gsp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mode,
    // External processor strobes, active low
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] bus_in,
    output logic [7:0] bus_out,
    output logic bus_oe,
    // CPU side
    input wire logic cpu_write,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_read,
    input wire logic overflow_clear,
    output logic [7:0] input_latch,
    output logic input_buffer_full,
    output logic output_buffer_full,
    output logic input_overflow
);
    gsp_bus_state_type state, next_state;
    logic [7:0] next_input_latch;
    logic [7:0] output_latch, next_output_latch;
    logic next_ibf, next_obf, next_input_overflow;
    logic write_done, read_done;

    always_comb begin
        next_state = state;
        write_done = 1'b0;
        read_done = 1'b0;
        next_input_latch = input_latch;
        case (state)
            GSP_IDLE: begin
                if (mode && !chip_select_n && !write_strobe_n) begin
                    next_state = GSP_WRITING;
                    next_input_latch = bus_in;
                end else if (mode && !chip_select_n && !read_strobe_n) begin
                    next_state = GSP_READING;
                end
            end
            GSP_WRITING: begin
                // Latch follows the bus while strobe and select are held and keeps the last word when either goes away
                if (!mode || chip_select_n || write_strobe_n) begin
                    next_state = GSP_IDLE;
                    write_done = mode;
                end else begin
                    next_input_latch = bus_in;
                end
            end
            GSP_READING: begin
                if (!mode || chip_select_n || read_strobe_n) begin
                    next_state = GSP_IDLE;
                    read_done = mode;
                end
            end
            default: next_state = GSP_IDLE;
        endcase
        next_output_latch = cpu_write ? cpu_wdata : output_latch;
        // Hardware set wins over a clear in the same cycle
        next_ibf = (input_buffer_full & ~cpu_read) | write_done;
        next_obf = (output_buffer_full & ~read_done) | cpu_write;
        next_input_overflow = (input_overflow & ~overflow_clear)
                    | (write_done & input_buffer_full & ~cpu_read);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= GSP_IDLE;
            input_latch <= LATCH_RESET;
            output_latch <= LATCH_RESET;
            input_buffer_full <= 1'b0;
            output_buffer_full <= 1'b0;
            input_overflow <= 1'b0;
            bus_out <= LATCH_RESET;
            bus_oe <= 1'b0;
        end else begin
            state <= next_state;
            input_latch <= next_input_latch;
            output_latch <= next_output_latch;
            input_buffer_full <= next_ibf;
            output_buffer_full <= next_obf;
            input_overflow <= next_input_overflow;
            bus_out <= next_output_latch;
            bus_oe <= (next_state == GSP_READING);
        end
    end
endmodule
`default_nettype wire
